// [tdm_net_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module tdm_net_partner #(parameter int WORD = 8, parameter int SLOTS = 4) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tx_o,
   input  wire logic       tx_oe,
   output logic            bclk,
   output logic            fsync,
   output logic            rx,
   output logic            driven,
   output logic            done,
   output logic [7:0]      word,
   output logic [4:0]      slot
);
   int   div;
   int   p;
   logic drv;
   // Bit clock never stops, even between frames
   always_ff @(posedge clk) begin
      done <= 1'b0;
      div <= (rst || div == 3) ? 0 : div + 1;
      if (rst) begin
         bclk <= 1'b0;
         fsync <= 1'b0;
         rx <= 1'b0;
         p <= WORD * SLOTS - 1;
         drv <= 1'b1;
      end else if (div == 3 && !bclk) begin
         bclk <= 1'b1;
         rx <= ~rx;
      end else if (div == 3) begin
         // Sample on the fall, midway through each bit
         bclk <= 1'b0;
         word <= {word[6:0], tx_o};
         driven <= drv & tx_oe;
         done <= p % WORD == WORD - 1;
         drv <= (p % WORD == WORD - 1) | (drv & tx_oe);
         slot <= 5'(p / WORD);
         p <= (p + 1) % (WORD * SLOTS);
         // Word-long sync over slot 0, seen high at the rise that opens it
         fsync <= (p + 1) % (WORD * SLOTS) < WORD;
      end
   end
endmodule // tdm_net_partner
`default_nettype wire

// [tdm_network_transmit_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tdm_network_mode_transmit_tb;
   logic        clock, cur_d, prev_none, reset = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, ck_o, ck_oe, fs_o, fs_oe;
   logic        tx_o, tx_oe, pbclk, pfs, prx, pdrv, pdone;
   logic [5:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rq, seed = 32'h0000_0036;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rr;
   logic [7:0]  pword, cur_w, held, dv;
   logic [4:0]  pslot;
   int          n_errors, cmp_count, cyc, a, i;

   tdm_network_tx dut (.CLOCK(clock), .RESET(reset), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .TRANSMIT_BIT_CLOCK_PIN_I(ck_oe ? ck_o : pbclk), .TRANSMIT_BIT_CLOCK_PIN_O(ck_o),
      .TRANSMIT_BIT_CLOCK_PIN_OE(ck_oe), .TRANSMIT_FRAME_SYNC_PIN_I(fs_oe ? fs_o : pfs),
      .TRANSMIT_FRAME_SYNC_PIN_O(fs_o), .TRANSMIT_FRAME_SYNC_PIN_OE(fs_oe),
      .SERIAL_TX_LINE_O(tx_o), .SERIAL_TX_LINE_OE(tx_oe), .SERIAL_RX_LINE_I(prx), .IRQ(irq));
   tdm_net_partner #(.WORD(8), .SLOTS(4)) far (.clk(clock), .rst(reset), .tx_o(tx_o),
      .tx_oe(tx_oe), .bclk(pbclk), .fsync(pfs), .rx(prx), .driven(pdrv), .done(pdone),
      .word(pword), .slot(pslot));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // TRANSMIT_DATA_EMPTY_FLAG survives the read; underrun only after an idle slot
   function automatic logic [3:0] exp_status(input logic none, input int k);
      return {k > 0, k % 4 == 0, none, 1'b1};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] dt);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clock);
      if (w) begin
         awaddr <= ad;
         wdata <= dt;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= ad;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      // Values read at the edge are those the slave samples there
      while (!tb) begin
         @(posedge clock);
         ta = w ? awready && awvalid : arready && arvalid;
         tw = wready && wvalid;
         tb = w ? bvalid && bready : rvalid && rready;
         rq = rdata;
         rr = w ? bresp : rresp;
         if (ta && w) awvalid <= 1'b0;
         if (ta && !w) arvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         if (tb) rready <= 1'b0;
      end
   endtask
   task automatic wait_done();
      do @(posedge clock); while (pdone !== 1'b1);
   endtask
   task print_verdict();
      $display("errors %0d checks %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // About forty slots of 64 cycles are needed
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      bus(1'b0, tdm_port_pkg::CONFIG_OFS, '0);
      chk(rq, tdm_port_pkg::CONFIG_RST, "config reset");
      bus(1'b0, 6'h20, '0);
      chk(rr, tdm_port_pkg::RESP_SLVERR, "unmapped read");
      bus(1'b1, 6'h20, '0);
      chk(rr, tdm_port_pkg::RESP_SLVERR, "unmapped write");
      bus(1'b1, tdm_port_pkg::MASK_OFS, 32'h0000_0001);
      bus(1'b1, tdm_port_pkg::CONFIG_OFS, 32'h0000_0003);
      bus(1'b1, tdm_port_pkg::CTRL_OFS, 32'h0000_0001);
      held = 8'hC3;
      // Word replicated so either byte lane carries it
      bus(1'b1, tdm_port_pkg::TXDATA_OFS, {4{held}});
      do bus(1'b0, tdm_port_pkg::STATUS_OFS, '0); while (rq[2] !== 1'b1);
      bus(1'b1, tdm_port_pkg::CTRL_OFS, 32'h0000_0007);
      do begin
         wait_done();
         chk(pdrv, 1'b0, "driven before frame");
      end while (pslot != 5'h03);
      cur_w = held;
      cur_d = 1'b1;
      prev_none = 1'b0;
      for (i = 0; i < 24; i++) begin
         @(posedge pbclk);
         @(negedge pbclk);
         chk(irq, 1'b1, "no data request");
         bus(1'b0, tdm_port_pkg::STATUS_OFS, '0);
         chk(rq[3:0], exp_status(prev_none, i), "status");
         a = (i < 3) ? i : int'(rnd() % 3);
         dv = 8'(rnd());
         if (a == 0) bus(1'b1, tdm_port_pkg::TXDATA_OFS, {4{dv}});
         if (a == 1) bus(1'b1, tdm_port_pkg::SKIP_OFS, '0);
         if (a != 2) chk(irq, 1'b0, "request not cleared");
         wait_done();
         chk(pdrv, cur_d, "slot drive");
         if (cur_d) chk(pword, cur_w, "slot word");
         if (a == 0) held = dv;
         cur_w = held;
         cur_d = a != 1;
         prev_none = a == 2;
      end
      @(posedge pbclk);
      @(negedge pbclk);
      bus(1'b1, tdm_port_pkg::CTRL_OFS, 32'h0000_0005);
      wait_done();
      chk(pdrv, cur_d, "last word drive");
      if (cur_d) chk(pword, cur_w, "last word");
      wait_done();
      chk(pdrv, 1'b0, "line after disable");
      // Partner's receive line toggles every bit, low on even bits
      bus(1'b0, tdm_port_pkg::RXDATA_OFS, '0);
      chk(rq, 32'h0000_0055, "received word");
      bus(1'b1, tdm_port_pkg::CONFIG_OFS, 32'h0000_0103);
      bus(1'b1, tdm_port_pkg::CTRL_OFS, 32'h0000_0009);
      chk({ck_oe, fs_oe}, 2'b11, "internal clock pins");
      // Two-cycle half period, 8 bits, 4 slots
      @(posedge fs_o);
      a = cyc;
      @(posedge fs_o);
      chk(cyc - a, 128, "internal frame length");
      bus(1'b1, tdm_port_pkg::MASK_OFS, '0);
      chk(irq, 1'b0, "masked request");
      print_verdict();
   end
endmodule // tdm_network_mode_transmit_tb
`default_nettype wire

// [tdm_network_tx.sv]
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module tdm_network_tx (
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire logic [5:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [5:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic        TRANSMIT_BIT_CLOCK_PIN_I,
   output logic             TRANSMIT_BIT_CLOCK_PIN_O,
   output logic             TRANSMIT_BIT_CLOCK_PIN_OE,
   input  wire logic        TRANSMIT_FRAME_SYNC_PIN_I,
   output logic             TRANSMIT_FRAME_SYNC_PIN_O,
   output logic             TRANSMIT_FRAME_SYNC_PIN_OE,
   output logic             SERIAL_TX_LINE_O,
   output logic             SERIAL_TX_LINE_OE,
   input  wire logic        SERIAL_RX_LINE_I,
   output logic             IRQ
);
   logic [31:0]                  control_reg_two;
   logic [31:0]                  transmit_config_reg;
   logic [3:0]                   status;
   logic [3:0]                   mask;
   logic [15:0]                  transmit_data_reg;
   logic [15:0]                  receive_data_reg;
   logic [15:0]                  transmit_shift_reg;
   logic [15:0]                  receive_shift_reg;
   logic                         aw_held;
   logic                         w_held;
   logic [5:0]                   aw_addr;
   logic [31:0]                  w_data;
   logic [3:0]                   w_strb;
   logic [31:0]                  w_bits;
   logic                         do_write;
   logic                         do_read;
   logic                         wr_data;
   logic                         wr_skip;
   logic                         rd_status;
   logic                         rd_rxdata;
   logic                         wrote_data;
   logic                         wrote_skip;
   logic [11:0]                  div_cnt;
   logic [11:0]                  half_period;
   logic                         bclk_int;
   logic                         bclk_prev;
   logic                         fs_prev;
   logic                         fs_level;
   logic                         bit_rise;
   logic                         bit_fall;
   logic [4:0]                   bit_cnt;
   logic [4:0]                   slot;
   logic [4:0]                   next_slot;
   logic                         last_bit;
   logic                         frame_start;
   logic                         word_edge;
   logic                         tx_load;
   logic                         slot_active;
   logic                         tx_bit;
   logic                         rx_run;
   logic [15:0]                  aligned;
   logic [15:0]                  word_mask;
   logic [15:0]                  rx_word;
   logic [3:0]                   set_bits;
   logic [3:0]                   clr_bits;
   tdm_port_pkg::tx_state_t      tx_state;

   logic       port_en;
   logic       tx_en;
   logic       rx_en;
   logic       int_clk;
   logic [4:0] slot_count_select;
   logic [1:0] word_length_select;
   logic [7:0] prescaler_modulus;
   logic       prescaler_range_bit;
   logic       frame_sync_invert;
   logic       frame_sync_length;
   logic [4:0] wl;

   assign port_en             = control_reg_two[tdm_port_pkg::PORT_EN_BIT];
   assign tx_en               = control_reg_two[tdm_port_pkg::TX_EN_BIT];
   assign rx_en               = control_reg_two[tdm_port_pkg::RX_EN_BIT];
   assign int_clk             = control_reg_two[tdm_port_pkg::INT_CLK_BIT];
   assign slot_count_select   = transmit_config_reg[tdm_port_pkg::SLOT_LSB +: 5];
   assign word_length_select  = transmit_config_reg[tdm_port_pkg::WL_LSB +: 2];
   assign prescaler_modulus   = transmit_config_reg[tdm_port_pkg::PM_LSB +: 8];
   assign prescaler_range_bit = transmit_config_reg[tdm_port_pkg::PSR_BIT];
   assign frame_sync_invert   = transmit_config_reg[tdm_port_pkg::FS_INV_BIT];
   assign frame_sync_length   = transmit_config_reg[tdm_port_pkg::FS_LEN_BIT];
   assign wl                  = tdm_port_pkg::word_bits(word_length_select);

   // AXI4-Lite slave: one write and one read in flight
   assign AWREADY   = !aw_held && !BVALID;
   assign WREADY    = !w_held && !BVALID;
   assign ARREADY   = !RVALID;
   assign do_write  = aw_held && w_held;
   assign do_read   = ARVALID && ARREADY;
   assign wr_data   = do_write && aw_addr == tdm_port_pkg::TXDATA_OFS && |w_strb;
   assign wr_skip   = do_write && aw_addr == tdm_port_pkg::SKIP_OFS && |w_strb;
   assign rd_status = do_read && ARADDR == tdm_port_pkg::STATUS_OFS;
   assign rd_rxdata = do_read && ARADDR == tdm_port_pkg::RXDATA_OFS;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         w_bits[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : 8'h00;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 6'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         BVALID  <= 1'b0;
         BRESP   <= tdm_port_pkg::RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            BVALID  <= 1'b1;
            unique case (aw_addr)
               tdm_port_pkg::CTRL_OFS, tdm_port_pkg::CONFIG_OFS, tdm_port_pkg::MASK_OFS,
               tdm_port_pkg::TXDATA_OFS, tdm_port_pkg::SKIP_OFS:
                  BRESP <= tdm_port_pkg::RESP_OKAY;
               default:
                  BRESP <= tdm_port_pkg::RESP_SLVERR;
            endcase
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // Byte-lane merge keeps untouched fields of a partial write to control and config; unstrobed transmit data lanes load zero
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         control_reg_two     <= tdm_port_pkg::CTRL_RST;
         transmit_config_reg <= tdm_port_pkg::CONFIG_RST;
         mask                <= tdm_port_pkg::STATUS_RST;
         transmit_data_reg   <= 16'h0000;
      end else if (do_write) begin
         for (int i = 0; i < 4; i++) begin
            if (w_strb[i] && aw_addr == tdm_port_pkg::CTRL_OFS) begin
               control_reg_two[i*8 +: 8] <= w_bits[i*8 +: 8] & tdm_port_pkg::CTRL_MASK[i*8 +: 8];
            end
            if (w_strb[i] && aw_addr == tdm_port_pkg::CONFIG_OFS) begin
               transmit_config_reg[i*8 +: 8] <=
                  w_bits[i*8 +: 8] & tdm_port_pkg::CONFIG_MASK[i*8 +: 8];
            end
         end
         if (aw_addr == tdm_port_pkg::MASK_OFS && w_strb[0]) begin
            mask <= w_data[tdm_port_pkg::STATUS_W-1:0];
         end
         if (wr_data) begin
            transmit_data_reg <= w_bits[15:0];
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0000_0000;
         RRESP  <= tdm_port_pkg::RESP_OKAY;
      end else if (do_read) begin
         RVALID <= 1'b1;
         RRESP  <= tdm_port_pkg::RESP_OKAY;
         unique case (ARADDR)
            tdm_port_pkg::CTRL_OFS:   RDATA <= control_reg_two;
            tdm_port_pkg::CONFIG_OFS: RDATA <= transmit_config_reg;
            tdm_port_pkg::STATUS_OFS: RDATA <= {28'h000_0000, status};
            tdm_port_pkg::MASK_OFS:   RDATA <= {28'h000_0000, mask};
            tdm_port_pkg::TXDATA_OFS: RDATA <= {16'h0000, transmit_data_reg};
            tdm_port_pkg::SKIP_OFS:   RDATA <= 32'h0000_0000;
            tdm_port_pkg::RXDATA_OFS: RDATA <= {16'h0000, receive_data_reg};
            tdm_port_pkg::SLOT_OFS:   RDATA <= {20'h0_0000, slot_active, tx_state[1],
                                                 slot, bit_cnt};
            default: begin
               RDATA <= 32'h0000_0000;
               RRESP <= tdm_port_pkg::RESP_SLVERR;
            end
         endcase
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // Internal bit clock is free running; there is no gated mode here
   assign half_period = ({4'h0, prescaler_modulus} + tdm_port_pkg::DIV_ONE)
                        << (prescaler_range_bit ? tdm_port_pkg::PSR_SHIFT : 0);

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         div_cnt   <= 12'h000;
         bclk_int  <= 1'b0;
         bclk_prev <= 1'b0;
      end else begin
         bclk_prev <= TRANSMIT_BIT_CLOCK_PIN_I;
         if (!(int_clk && port_en)) begin
            div_cnt  <= 12'h000;
            bclk_int <= 1'b0;
         end else if (div_cnt == 12'h000) begin
            div_cnt  <= half_period - tdm_port_pkg::DIV_ONE;
            bclk_int <= !bclk_int;
         end else begin
            div_cnt <= div_cnt - tdm_port_pkg::DIV_ONE;
         end
      end
   end

   always_comb begin
      if (int_clk) begin
         bit_rise = port_en && div_cnt == 12'h000 && !bclk_int;
         bit_fall = port_en && div_cnt == 12'h000 && bclk_int;
      end else begin
         bit_rise = port_en && TRANSMIT_BIT_CLOCK_PIN_I && !bclk_prev;
         bit_fall = port_en && !TRANSMIT_BIT_CLOCK_PIN_I && bclk_prev;
      end
   end

   // Slot and bit counting against the slot count; an external frame sync also restarts it
   assign fs_level    = TRANSMIT_FRAME_SYNC_PIN_I ^ frame_sync_invert;
   assign last_bit    = bit_cnt == wl - 5'h01;
   assign frame_start = int_clk ? (bit_rise && last_bit && slot == slot_count_select)
                                : (bit_rise && fs_level && !fs_prev);
   assign word_edge   = bit_rise && (last_bit || frame_start);
   assign next_slot   = (frame_start || slot == slot_count_select) ? 5'h00 : slot + 5'h01;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         bit_cnt <= 5'h00;
         slot    <= 5'h00;
         fs_prev <= 1'b0;
         TRANSMIT_FRAME_SYNC_PIN_O <= 1'b0;
      end else if (bit_rise) begin
         fs_prev <= fs_level;
         if (word_edge) begin
            bit_cnt <= 5'h00;
            slot    <= next_slot;
            TRANSMIT_FRAME_SYNC_PIN_O <= (next_slot == 5'h00) ^ frame_sync_invert;
         end else begin
            bit_cnt <= bit_cnt + 5'h01;
            if (frame_sync_length) begin
               TRANSMIT_FRAME_SYNC_PIN_O <= frame_sync_invert;
            end
         end
      end
   end

   assign TRANSMIT_BIT_CLOCK_PIN_O   = bclk_int;
   assign TRANSMIT_BIT_CLOCK_PIN_OE  = int_clk && port_en;
   assign TRANSMIT_FRAME_SYNC_PIN_OE = int_clk && port_en;

   // Transmit sequencing: start on a frame, stop only on a word edge
   assign tx_load = word_edge && port_en && tx_en
                    && (tx_state == tdm_port_pkg::TX_RUN || frame_start);

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         tx_state <= tdm_port_pkg::TX_OFF;
      end else begin
         unique case (tx_state)
            tdm_port_pkg::TX_OFF: if (tx_load) tx_state <= tdm_port_pkg::TX_RUN;
            tdm_port_pkg::TX_RUN: if (word_edge && !tx_load) tx_state <= tdm_port_pkg::TX_OFF;
         endcase
      end
   end

   // Writes before a word edge count toward the next slot; a write in the edge cycle carries over
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         wrote_data <= 1'b0;
         wrote_skip <= 1'b0;
      end else begin
         wrote_data <= wr_data || (wrote_data && !tx_load);
         wrote_skip <= wr_skip || (wrote_skip && !tx_load);
      end
   end

   assign aligned = transmit_data_reg << (5'h10 - wl);

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         transmit_shift_reg <= 16'h0000;
         tx_bit             <= 1'b0;
         slot_active        <= 1'b0;
      end else if (tx_load) begin
         slot_active <= !wrote_skip;
         if (!wrote_skip) begin
            tx_bit             <= aligned[15];
            transmit_shift_reg <= aligned << 1;
         end
      end else if (bit_rise) begin
         if (word_edge) begin
            slot_active <= 1'b0;
         end
         tx_bit             <= transmit_shift_reg[15];
         transmit_shift_reg <= transmit_shift_reg << 1;
      end
   end

   assign SERIAL_TX_LINE_O  = tx_bit;
   assign SERIAL_TX_LINE_OE = tx_state == tdm_port_pkg::TX_RUN && slot_active;

   // Receiver shifts on falling edges and lands every slot's word
   assign word_mask = 16'hFFFF >> (5'h10 - wl);
   assign rx_word   = {receive_shift_reg[14:0], SERIAL_RX_LINE_I} & word_mask;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         rx_run            <= 1'b0;
         receive_shift_reg <= 16'h0000;
         receive_data_reg  <= 16'h0000;
      end else begin
         if (frame_start) begin
            rx_run <= port_en && rx_en;
         end else if (!(port_en && rx_en)) begin
            rx_run <= 1'b0;
         end
         if (bit_fall && rx_run) begin
            receive_shift_reg <= rx_word;
            if (last_bit) begin
               receive_data_reg <= rx_word;
            end
         end
      end
   end

   // Sticky status: set wins over any clear in the same cycle
   always_comb begin
      set_bits = 4'h0;
      clr_bits = 4'h0;
      set_bits[tdm_port_pkg::ST_TDE]      = tx_load;
      set_bits[tdm_port_pkg::ST_UNDERRUN] = tx_load && !wrote_data && !wrote_skip;
      set_bits[tdm_port_pkg::ST_FRAME]    = frame_start;
      set_bits[tdm_port_pkg::ST_RXRDY]    = bit_fall && rx_run && last_bit;
      clr_bits[tdm_port_pkg::ST_TDE]      = wr_data || wr_skip;
      clr_bits[tdm_port_pkg::ST_RXRDY]    = rd_rxdata;
      if (rd_status) begin
         clr_bits = clr_bits | tdm_port_pkg::READ_CLEAR;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         status <= tdm_port_pkg::STATUS_RST;
      end else begin
         status <= set_bits | (status & ~clr_bits);
      end
   end

   assign IRQ = |(status & mask);

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   AST_TX_OFF_TRISTATE: assert property (
      tx_state == tdm_port_pkg::TX_OFF |-> !SERIAL_TX_LINE_OE)
      else $error("transmit line driven while transmitter off");
   AST_START_ON_FRAME: assert property (
      $rose(tx_state == tdm_port_pkg::TX_RUN) |-> $past(frame_start))
      else $error("transmitter started away from frame boundary");
   AST_NEEDS_ENABLES: assert property (
      tx_state == tdm_port_pkg::TX_OFF && !(port_en && tx_en) |=> tx_state == tdm_port_pkg::TX_OFF)
      else $error("transmitter started without both enables");
   AST_EMPTY_EACH_WORD: assert property (
      tx_load ##1 mask[tdm_port_pkg::ST_TDE] |-> status[tdm_port_pkg::ST_TDE] && IRQ)
      else $error("empty flag or interrupt missing at word start");
   AST_WRITE_CLEARS_EMPTY: assert property (
      (wr_data || wr_skip) && !tx_load |=> !status[tdm_port_pkg::ST_TDE])
      else $error("data or skip write did not clear empty flag");
   AST_SKIP_TRISTATES: assert property (
      tx_load && wrote_skip |=> !SERIAL_TX_LINE_OE [*2])
      else $error("skipped slot was driven");
   AST_UNDERRUN_RESEND: assert property (
      tx_load && !wrote_data && !wrote_skip
      |=> status[tdm_port_pkg::ST_UNDERRUN] && SERIAL_TX_LINE_OE && tx_bit == $past(aligned[15]))
      else $error("underrun not flagged or held word not resent");
   AST_UNDERRUN_STICKY: assert property (
      status[tdm_port_pkg::ST_UNDERRUN] && !rd_status |=> status[tdm_port_pkg::ST_UNDERRUN])
      else $error("underrun flag lost without status read");
   AST_SHIFT_PER_EDGE: assert property (
      bit_rise && !word_edge && SERIAL_TX_LINE_OE |=> tx_bit == $past(transmit_shift_reg[15]))
      else $error("shifter did not advance one bit");
   AST_SLOT_WRAP: assert property (
      word_edge && !frame_start && slot == slot_count_select |=> slot == 5'h00)
      else $error("slot counter did not wrap at slot count");
   AST_RX_WORD_LANDS: assert property (
      bit_fall && rx_run && last_bit |=> status[tdm_port_pkg::ST_RXRDY]
      && receive_data_reg == $past(rx_word))
      else $error("received word not moved to receive register");

   COV_UNDERRUN: cover property (tx_load && !wrote_data && !wrote_skip);
   COV_SKIP_SLOT: cover property (tx_load && wrote_skip);
   COV_TX_START: cover property ($rose(tx_state == tdm_port_pkg::TX_RUN));
   COV_RX_WORD: cover property (bit_fall && rx_run && last_bit);
endmodule // tdm_network_tx
`default_nettype wire

// [tdm_port_pkg.sv]
package tdm_port_pkg;
   localparam int          ADDR_W        = 6;
   localparam int          DATA_W        = 16;
   // Register offsets (byte addresses)
   localparam logic [5:0]  CTRL_OFS      = 6'h00;
   localparam logic [5:0]  CONFIG_OFS    = 6'h04;
   localparam logic [5:0]  STATUS_OFS    = 6'h08;
   localparam logic [5:0]  MASK_OFS      = 6'h0C;
   localparam logic [5:0]  TXDATA_OFS    = 6'h10;
   localparam logic [5:0]  SKIP_OFS      = 6'h14;
   localparam logic [5:0]  RXDATA_OFS    = 6'h18;
   localparam logic [5:0]  SLOT_OFS      = 6'h1C;
   // Control register two fields
   localparam int          PORT_EN_BIT   = 0;
   localparam int          TX_EN_BIT     = 1;
   localparam int          RX_EN_BIT     = 2;
   localparam int          INT_CLK_BIT   = 3;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK     = 32'h0000_000F;
   // Transmit config register fields
   localparam int          SLOT_LSB      = 0;
   localparam int          WL_LSB        = 5;
   localparam int          PM_LSB        = 8;
   localparam int          PSR_BIT       = 16;
   localparam int          FS_INV_BIT    = 17;
   localparam int          FS_LEN_BIT    = 18;
   localparam logic [31:0] CONFIG_RST    = 32'h0000_0001;
   localparam logic [31:0] CONFIG_MASK   = 32'h0007_FF7F;
   // Status bits, mask uses the same layout
   localparam int          STATUS_W      = 4;
   localparam int          ST_TDE        = 0;
   localparam int          ST_UNDERRUN   = 1;
   localparam int          ST_FRAME      = 2;
   localparam int          ST_RXRDY      = 3;
   localparam logic [3:0]  STATUS_RST    = 4'h0;
   localparam logic [3:0]  READ_CLEAR    = 4'hE;
   // Bit clock divider
   localparam int          PSR_SHIFT     = 3;
   localparam logic [11:0] DIV_ONE       = 12'h001;
   // Word lengths
   localparam logic [4:0]  WL_BITS_8     = 5'h08;
   localparam logic [4:0]  WL_BITS_10    = 5'h0A;
   localparam logic [4:0]  WL_BITS_12    = 5'h0C;
   localparam logic [4:0]  WL_BITS_16    = 5'h10;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      TX_OFF = 2'b01,
      TX_RUN = 2'b10
   } tx_state_t;

   function automatic logic [4:0] word_bits(input logic [1:0] sel);
      logic [4:0] n;
      n = WL_BITS_8;
      unique case (sel)
         2'h0: n = WL_BITS_8;
         2'h1: n = WL_BITS_10;
         2'h2: n = WL_BITS_12;
         2'h3: n = WL_BITS_16;
      endcase
      return n;
   endfunction
endpackage
